// *** rtl/wdg_pkg.sv ***
/*
  Package for the watchdog and reset-cause block: register offsets,
  field layouts, reset values, mode coding and timing constants.
  Assumes an 8-bit register port and a single system clock.
*/
package wdg_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] WDG_CTRL_OFFSET = 8'h60;
  localparam logic [7:0] WDG_STATUS_OFFSET = 8'h61;
  localparam logic [7:0] WDG_STATUS_USED_MASK = 8'h0f;
  localparam logic [7:0] WDG_READ_IDLE = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int WDG_OSC_FREQ_HZ = 128000;
  localparam int WDG_BASE_CYCLES = 2048;
  localparam logic [3:0] WDG_MAX_SEL = 4'h9;
  localparam int WDG_COUNT_WIDTH = 21;
  localparam logic [2:0] WDG_UNLOCK_CYCLES = 3'h4;
  localparam logic WDG_FUSE_PROGRAMMED = 1'b0;

  // ------------------------------------------------------------------
  // Field layouts and modes
  // ------------------------------------------------------------------
  typedef struct packed {
    logic irqFlag;
    logic irqEnable;
    logic prescaleHigh;
    logic changeUnlock;
    logic resetEnable;
    logic [2:0] prescaleLow;
  } wdg_ctrl_type;

  typedef struct packed {
    logic [3:0] unused;
    logic dogResetCause;
    logic brownoutCause;
    logic pinResetCause;
    logic powerupCause;
  } wdg_status_type;

  typedef struct packed {
    logic powerOn;
    logic brownout;
    logic pinReset;
  } wdg_reset_event_type;

  typedef enum logic [1:0] {
    WDG_STOPPED,
    WDG_IRQ_ONLY,
    WDG_RESET_ONLY,
    WDG_IRQ_THEN_RESET
  } wdg_mode_type;

  localparam wdg_ctrl_type WDG_CTRL_RESET = '0;
  localparam wdg_status_type WDG_STATUS_RESET = '0;

endpackage : wdg_pkg

// *** rtl/wdg_watchdog.sv ***
/*
  Watchdog timer with interrupt, reset and combined modes, timed change
  window, always-on fuse and reset-cause status flags.
  Assumes: register master on clk; oscillator and fuse arrive as pins
  and are synchronised here; reset-source events are clk-domain pulses.
*/
// Behaviour
// - Time-out in interrupt mode sets flag; vector run or write-one clears it.
// - Interrupt request only while global enable and watchdog enable are set.
// - Combined mode: first time-out sets flag; vector clears flag and enable.
// - Combined mode: unserviced flag at next time-out causes system reset.
// - Enable pair selects stopped, interrupt, reset or combined mode.
// - Programmed fuse forces system reset mode regardless of control bits.
// - Clearing reset enable or changing prescaler needs open change window.
// - Change-unlock bit self-clears four system clock cycles after set.
// - Watchdog reset cause flag forces reset enable to one.
// - Prescaler code selects 2048 cycles doubling up to 1048576 cycles.
// - Watchdog reset cause set by dog reset, cleared by power-on or write zero.
// - Brown-out cause set by brown-out, cleared by power-on or write zero.
// - Pin reset cause set by pin reset, cleared by power-on or write zero.
// - Power-up cause set by power-on, cleared only by writing zero.
// - Upper four status bits always read zero.
// - Reset caused by the watchdog leaves the watchdog enabled.
// - Counter counts cycles of the separate slow oscillator.
// - Programmed fuse locks reset enable at one, interrupt enable at zero.
// - Restart command restarts the counter.
`timescale 1ns/10ps

module wdg_watchdog
  import wdg_pkg::*;
#(
  parameter int TIMEOUT_BASE = WDG_BASE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic oscClkIn,
  input wire logic forceAlwaysOnFuse,
  input wire logic restartCmd,
  input wire logic globalIrqEnable,
  input wire logic irqVectorAck,
  input wire wdg_reset_event_type resetEvents,
  output logic timeoutIrqReq,
  output logic systemResetReq
);

  // ------------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------------
  logic oscSync1;
  logic oscSync2;
  logic oscPrev;
  logic fuseSync1;
  logic fuseSync2;

  // Fuse resets to programmed so the dog is safe until the pin is seen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oscSync1 <= 1'b0;
      oscSync2 <= 1'b0;
      oscPrev <= 1'b0;
      fuseSync1 <= WDG_FUSE_PROGRAMMED;
      fuseSync2 <= WDG_FUSE_PROGRAMMED;
    end
    else
    begin
      oscSync1 <= oscClkIn;
      oscSync2 <= oscSync1;
      oscPrev <= oscSync2;
      fuseSync1 <= forceAlwaysOnFuse;
      fuseSync2 <= fuseSync1;
    end
  end

  // ------------------------------------------------------------------
  // Decode and mode
  // ------------------------------------------------------------------
  wdg_ctrl_type ctrl;
  wdg_ctrl_type wrCtrl;
  wdg_status_type status;
  wdg_status_type wrStatus;
  wdg_mode_type mode;
  logic [WDG_COUNT_WIDTH-1:0] count;
  logic [WDG_COUNT_WIDTH-1:0] terminalCount;
  logic [3:0] prescale;
  logic [3:0] selClamped;
  logic [2:0] unlockCount;
  logic fuseForced;
  logic oscTick;
  logic timeoutHit;
  logic dogReset;
  logic setIrqFlag;
  logic anyReset;
  logic ctrlWrite;
  logic statusWrite;

  assign wrCtrl = wdg_ctrl_type'(regWrData);
  assign wrStatus = wdg_status_type'(regWrData);
  assign ctrlWrite = regWrite && (regAddr == WDG_CTRL_OFFSET);
  assign statusWrite = regWrite && (regAddr == WDG_STATUS_OFFSET);
  assign fuseForced = (fuseSync2 == WDG_FUSE_PROGRAMMED);
  assign oscTick = oscSync2 && !oscPrev;
  assign prescale = {ctrl.prescaleHigh, ctrl.prescaleLow};

  // Reserved codes above the top entry run at the longest period
  assign selClamped = (prescale > WDG_MAX_SEL) ? WDG_MAX_SEL : prescale;
  assign terminalCount = (WDG_COUNT_WIDTH'(TIMEOUT_BASE) << selClamped)
                         - WDG_COUNT_WIDTH'(1);

  // Mode selection from the enable pair, overridden by the fuse
  always_comb
  begin
    if (fuseForced)
      mode = WDG_RESET_ONLY;
    else
    begin
      unique case ({ctrl.resetEnable, ctrl.irqEnable})
        2'b00: mode = WDG_STOPPED;
        2'b01: mode = WDG_IRQ_ONLY;
        2'b10: mode = WDG_RESET_ONLY;
        2'b11: mode = WDG_IRQ_THEN_RESET;
      endcase
    end
  end

  // Compare with >= so a shortened period times out at the next oscillator tick
  assign timeoutHit = oscTick && (mode != WDG_STOPPED) && (count >= terminalCount);
  assign dogReset = timeoutHit && ((mode == WDG_RESET_ONLY)
                    || ((mode == WDG_IRQ_THEN_RESET) && ctrl.irqFlag));
  assign setIrqFlag = timeoutHit && ((mode == WDG_IRQ_ONLY)
                      || ((mode == WDG_IRQ_THEN_RESET) && !ctrl.irqFlag));
  assign anyReset = dogReset || resetEvents.powerOn || resetEvents.brownout
                    || resetEvents.pinReset;

  // ------------------------------------------------------------------
  // Time-out counter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else if (restartCmd || anyReset || (mode == WDG_STOPPED) || timeoutHit)
      count <= '0;
    else if (oscTick)
      count <= count + WDG_COUNT_WIDTH'(1);
  end

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  // Interrupt flag: hardware set wins over a vector or write-one clear in the same cycle; a reset event wins over the set
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl.irqFlag <= WDG_CTRL_RESET.irqFlag;
    else if (anyReset)
      ctrl.irqFlag <= WDG_CTRL_RESET.irqFlag;
    else if (setIrqFlag)
      ctrl.irqFlag <= 1'b1;
    else if (irqVectorAck || (ctrlWrite && wrCtrl.irqFlag))
      ctrl.irqFlag <= 1'b0;
  end

  // Interrupt enable: locked off by the fuse, dropped by the vector in combined mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl.irqEnable <= WDG_CTRL_RESET.irqEnable;
    else if (fuseForced || anyReset)
      ctrl.irqEnable <= 1'b0;
    else if (irqVectorAck && (mode == WDG_IRQ_THEN_RESET))
      ctrl.irqEnable <= 1'b0;
    else if (ctrlWrite)
      ctrl.irqEnable <= wrCtrl.irqEnable;
  end

  // Prescaler only moves inside an open change window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl.prescaleHigh <= WDG_CTRL_RESET.prescaleHigh;
      ctrl.prescaleLow <= WDG_CTRL_RESET.prescaleLow;
    end
    else if (anyReset)
    begin
      ctrl.prescaleHigh <= WDG_CTRL_RESET.prescaleHigh;
      ctrl.prescaleLow <= WDG_CTRL_RESET.prescaleLow;
    end
    else if (ctrlWrite && ctrl.changeUnlock)
    begin
      ctrl.prescaleHigh <= wrCtrl.prescaleHigh;
      ctrl.prescaleLow <= wrCtrl.prescaleLow;
    end
  end

  // Change window: high for exactly four cycles after the unlocking write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl.changeUnlock <= WDG_CTRL_RESET.changeUnlock;
      unlockCount <= '0;
    end
    else if (anyReset)
    begin
      ctrl.changeUnlock <= WDG_CTRL_RESET.changeUnlock;
      unlockCount <= '0;
    end
    else if (ctrlWrite && wrCtrl.changeUnlock)
    begin
      ctrl.changeUnlock <= 1'b1;
      unlockCount <= WDG_UNLOCK_CYCLES - 3'h1;
    end
    else if (unlockCount != '0)
      unlockCount <= unlockCount - 3'h1;
    else
      ctrl.changeUnlock <= 1'b0;
  end

  // Reset enable: set freely, cleared only in the window and without cause
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl.resetEnable <= WDG_CTRL_RESET.resetEnable;
    else if (fuseForced || status.dogResetCause || dogReset)
      ctrl.resetEnable <= 1'b1;
    else if (anyReset)
      ctrl.resetEnable <= WDG_CTRL_RESET.resetEnable;
    else if (ctrlWrite && (wrCtrl.resetEnable || ctrl.changeUnlock))
      ctrl.resetEnable <= wrCtrl.resetEnable;
  end

  // ------------------------------------------------------------------
  // Reset-cause status
  // ------------------------------------------------------------------
  // Each cause is sticky; a new event wins over a software clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status <= WDG_STATUS_RESET;
    else
    begin
      status.unused <= WDG_STATUS_RESET.unused;
      if (dogReset)
        status.dogResetCause <= 1'b1;
      else if (resetEvents.powerOn || (statusWrite && !wrStatus.dogResetCause))
        status.dogResetCause <= 1'b0;
      if (resetEvents.brownout)
        status.brownoutCause <= 1'b1;
      else if (resetEvents.powerOn || (statusWrite && !wrStatus.brownoutCause))
        status.brownoutCause <= 1'b0;
      if (resetEvents.pinReset)
        status.pinResetCause <= 1'b1;
      else if (resetEvents.powerOn || (statusWrite && !wrStatus.pinResetCause))
        status.pinResetCause <= 1'b0;
      if (resetEvents.powerOn)
        status.powerupCause <= 1'b1;
      else if (statusWrite && !wrStatus.powerupCause)
        status.powerupCause <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= WDG_READ_IDLE;
    else if (regRead && (regAddr == WDG_CTRL_OFFSET))
      regRdData <= ctrl;
    else if (regRead && (regAddr == WDG_STATUS_OFFSET))
      regRdData <= status & WDG_STATUS_USED_MASK;
    else
      regRdData <= WDG_READ_IDLE;
  end

  // One-cycle reset pulse to the reset controller
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      systemResetReq <= 1'b0;
    else
      systemResetReq <= dogReset;
  end

  assign timeoutIrqReq = ctrl.irqFlag && ctrl.irqEnable && globalIrqEnable;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  flag_set_a: assert property ((setIrqFlag && !anyReset) |=> ctrl.irqFlag)
    else $error("interrupt flag not set on time-out");
  flag_clear_a: assert property ((irqVectorAck && !setIrqFlag && !anyReset)
    |=> !ctrl.irqFlag)
    else $error("interrupt flag not cleared by vector");
  irq_gate_a: assert property ((ctrl.irqFlag && ctrl.irqEnable && !globalIrqEnable)
    |-> !timeoutIrqReq)
    else $error("interrupt requested with global enable low");
  combo_ack_a: assert property ((irqVectorAck && (mode == WDG_IRQ_THEN_RESET))
    |=> !ctrl.irqEnable && ctrl.resetEnable)
    else $error("combined mode did not fall back to reset mode");
  combo_reset_a: assert property ((timeoutHit && (mode == WDG_IRQ_THEN_RESET)
    && ctrl.irqFlag) |=> systemResetReq)
    else $error("no reset on unserviced second time-out");
  fuse_lock_a: assert property (fuseForced |=> ctrl.resetEnable && !ctrl.irqEnable)
    else $error("fuse did not lock the enable bits");
  unlock_close_a: assert property ((ctrlWrite && wrCtrl.changeUnlock)
    ##1 (!(ctrlWrite && wrCtrl.changeUnlock) && !anyReset)[*4]
    |=> !ctrl.changeUnlock)
    else $error("change window not closed after four cycles");
  prescale_lock_a: assert property ((ctrlWrite && !ctrl.changeUnlock && !anyReset)
    |=> $stable(prescale))
    else $error("prescaler changed outside the window");
  dog_sticky_a: assert property (status.dogResetCause |=> ctrl.resetEnable)
    else $error("reset enable dropped while dog cause set");
  dog_flag_a: assert property (systemResetReq |-> status.dogResetCause)
    else $error("dog reset cause missing after dog reset");
  status_zero_a: assert property ((regRead && (regAddr == WDG_STATUS_OFFSET))
    |=> (regRdData & ~WDG_STATUS_USED_MASK) == WDG_READ_IDLE)
    else $error("reserved status bits read non-zero");

  combo_flow_c: cover property (setIrqFlag && (mode == WDG_IRQ_THEN_RESET)
    ##[1:1000] dogReset);
  unlock_change_c: cover property ((ctrlWrite && wrCtrl.changeUnlock)
    ##[1:4] (ctrlWrite && !wrCtrl.resetEnable && ctrl.changeUnlock));
  irq_request_c: cover property ($rose(timeoutIrqReq));

endmodule : wdg_watchdog

// *** test/wdg_cpu_model.sv ***
/*
  Processor-side model: free-running slow watchdog oscillator and
  interrupt vector entry after a settable latency.
  Assumes the bench drives the register port and the global enable.
*/
`timescale 1ns/10ps

module wdg_cpu_model
#(
  parameter int OSC_HALF_NS = 40,
  parameter int ACK_DELAY = 2
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic timeoutIrqReq,
  input wire logic ackEnable,
  output logic oscClkIn,
  output logic irqVectorAck
);
  int waitCnt;

  // ------------------------------------------------------------------
  // Oscillator
  // ------------------------------------------------------------------
  // Free running and unrelated in phase to clk, as a real RC source is
  initial
  begin
    oscClkIn = 1'b0;
    #3;
    forever #(OSC_HALF_NS) oscClkIn = ~oscClkIn;
  end

  // ------------------------------------------------------------------
  // Vector entry
  // ------------------------------------------------------------------
  // One pulse per request; counter restarts so a held request is acked again only after the full ACK_DELAY latency
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqVectorAck <= 1'b0;
      waitCnt <= 0;
    end
    else
    begin
      irqVectorAck <= 1'b0;
      if (irqVectorAck || !(ackEnable && timeoutIrqReq === 1'b1))
        waitCnt <= 0;
      else if (waitCnt == ACK_DELAY)
        irqVectorAck <= 1'b1;
      else
        waitCnt <= waitCnt + 1;
    end
  end
endmodule : wdg_cpu_model

// *** test/tb_wdg_watchdog.sv ***
/*
  Testbench for the watchdog block: register tasks, reset-cause events,
  change window, modes, time-out lengths and the fuse.
  Assumes TIMEOUT_BASE of 4 and an oscillator period of ten clk cycles.
*/
`timescale 1ns/10ps

module tb_wdg_watchdog
  import wdg_pkg::*;
;
  localparam logic [7:0] CT = WDG_CTRL_OFFSET;
  localparam logic [7:0] ST = WDG_STATUS_OFFSET;
  localparam int OSC = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrite, regRead, forceAlwaysOnFuse, restartCmd, globalIrqEnable;
  logic oscClkIn, irqVectorAck, ackEnable, timeoutIrqReq, systemResetReq;
  wdg_reset_event_type resetEvents;
  // A reserved code first, then shortening periods so later waits stay short
  logic [3:0] sels [5] = '{4'hc, 4'h9, 4'h5, 4'h1, 4'h0};
  int n_fail = 0;
  int n_checks = 0;
  int n, p;

  wdg_watchdog #(.TIMEOUT_BASE(4)) wdg_watchdog_i (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .oscClkIn(oscClkIn), .forceAlwaysOnFuse(forceAlwaysOnFuse),
    .restartCmd(restartCmd), .globalIrqEnable(globalIrqEnable),
    .irqVectorAck(irqVectorAck), .resetEvents(resetEvents),
    .timeoutIrqReq(timeoutIrqReq), .systemResetReq(systemResetReq));
  wdg_cpu_model #(.OSC_HALF_NS(40), .ACK_DELAY(2)) wdg_cpu_model_i (.clk(clk),
    .reset_n(reset_n), .timeoutIrqReq(timeoutIrqReq), .ackEnable(ackEnable),
    .oscClkIn(oscClkIn), .irqVectorAck(irqVectorAck));

  // Clock
  always #4 clk = ~clk;

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk_byte

  task automatic chk_span(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi)
    begin
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      n_fail++;
    end
  endtask : chk_span

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  // Data is registered: it stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk_byte(nm, e, regRdData);
  endtask : rd_chk

  // Second write lands in the second cycle of the window; the extra edge
  // lets the window close so that a following read sees bit 4 low
  task automatic unlock_set(input logic [7:0] d);
    wr(CT, 8'h18);
    wr(CT, d);
    @(posedge clk);
  endtask : unlock_set

  task automatic pulse(input bit isEvent, input wdg_reset_event_type e);
    @(posedge clk);
    if (isEvent)
      resetEvents <= e;
    else
      restartCmd <= 1'b1;
    @(posedge clk);
    resetEvents <= '0;
    restartCmd <= 1'b0;
  endtask : pulse

  // Bounded wait; returns limit when the output never rose
  task automatic wait_for(input bit rst, input int limit, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < limit)
    begin
      @(posedge clk);
      #1;
      cnt++;
      hit = rst ? (systemResetReq === 1'b1) : (timeoutIrqReq === 1'b1);
    end
  endtask : wait_for

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    {regAddr, regWrData, regWrite, regRead, restartCmd, globalIrqEnable} = '0;
    {ackEnable, resetEvents} = '0;
    forceAlwaysOnFuse = 1'b1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Fuse synchroniser starts at programmed, so reset enable comes up set
    rd_chk(CT, 8'h08, "ctrl after reset");
    unlock_set(8'h00);
    rd_chk(CT, 8'h00, "ctrl after start-up");
    rd_chk(ST, 8'h00, "status after reset");
    wr(8'h62, 8'hff);
    rd_chk(8'h62, 8'h00, "unmapped read");
    pulse(1, 3'b100);
    rd_chk(ST, 8'h01, "powerup cause");
    pulse(1, 3'b010);
    pulse(1, 3'b001);
    rd_chk(ST, 8'h07, "brownout and pin causes");
    wr(ST, 8'hf9);
    rd_chk(ST, 8'h01, "causes cleared by zero");
    pulse(1, 3'b010);
    pulse(1, 3'b001);
    pulse(1, 3'b100);
    rd_chk(ST, 8'h01, "power-on clears causes");
    wr(ST, 8'hff);
    rd_chk(ST, 8'h01, "upper bits zero");
    wr(ST, 8'h00);
    rd_chk(ST, 8'h00, "powerup cleared by zero");
    // Change window: refused without it, open up to four cycles after
    wr(CT, 8'h08);
    pulse(0, '0);
    wr(CT, 8'h00);
    wr(CT, 8'h09);
    rd_chk(CT, 8'h08, "locked without window");
    wr(CT, 8'h18);
    rd_chk(CT, 8'h18, "window open");
    wr(CT, 8'h00);
    rd_chk(CT, 8'h00, "clear in fourth cycle");
    wr(CT, 8'h08);
    pulse(0, '0);
    wr(CT, 8'h18);
    repeat (3) @(posedge clk);
    wr(CT, 8'h00);
    rd_chk(CT, 8'h08, "fifth cycle refused");
    unlock_set(8'h00);
    pulse(0, '0);
    wait_for(1, 100, n);
    chk_span("stopped mode", 100, 100, n);
    // Time-out length for several prescale codes, interrupt-only mode
    @(posedge clk) globalIrqEnable <= 1'b1;
    foreach (sels[i])
    begin
      // Reserved codes run at the longest period
      p = 4 << ((sels[i] > WDG_MAX_SEL) ? WDG_MAX_SEL : sels[i]);
      pulse(0, '0);
      unlock_set({2'b11, sels[i][3], 2'b00, sels[i][2:0]});
      pulse(0, '0);
      wait_for(0, p * OSC + 40, n);
      chk_span("time-out length", (p - 1) * OSC - 2, p * OSC + 10, n);
    end
    // Interrupt gating and both ways of clearing the flag
    @(posedge clk) globalIrqEnable <= 1'b0;
    wr(CT, 8'hc0);
    pulse(0, '0);
    wait_for(0, 60, n);
    chk_span("masked request", 60, 60, n);
    rd_chk(CT, 8'hc0, "flag set");
    pulse(0, '0);
    wr(CT, 8'hc0);
    rd_chk(CT, 8'h40, "flag write one");
    @(posedge clk);
    ackEnable <= 1'b1;
    globalIrqEnable <= 1'b1;
    wait_for(0, 60, n);
    chk_span("request", 1, 59, n);
    repeat (5) @(posedge clk);
    rd_chk(CT, 8'h40, "vector clears flag");
    // Combined mode, serviced then unserviced
    wr(CT, 8'h48);
    pulse(0, '0);
    wait_for(0, 60, n);
    chk_span("combined first", 1, 59, n);
    repeat (5) @(posedge clk);
    rd_chk(CT, 8'h08, "vector drops enable");
    wait_for(1, 60, n);
    chk_span("reset mode", 1, 59, n);
    rd_chk(ST, 8'h08, "dog cause");
    rd_chk(CT, 8'h08, "stays enabled");
    @(posedge clk) ackEnable <= 1'b0;
    wr(CT, 8'h48);
    pulse(0, '0);
    wait_for(0, 60, n);
    chk_span("unserviced first", 1, 59, n);
    chk_byte("no early reset", 8'h00, {7'h00, systemResetReq});
    wait_for(1, 60, n);
    chk_span("unserviced reset", 1, 59, n);
    pulse(0, '0);
    unlock_set(8'h00);
    rd_chk(CT, 8'h08, "cause holds enable");
    pulse(1, 3'b100);
    rd_chk(ST, 8'h01, "power-on clears dog cause");
    pulse(0, '0);
    wr(ST, 8'h00);
    unlock_set(8'h00);
    rd_chk(CT, 8'h00, "disable after cause cleared");
    // Programmed fuse forces reset mode
    @(posedge clk) forceAlwaysOnFuse <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(CT, 8'h08, "fuse forces reset enable");
    wr(CT, 8'h40);
    unlock_set(8'h00);
    rd_chk(CT, 8'h08, "fuse locks bits");
    pulse(0, '0);
    wait_for(1, 60, n);
    chk_span("fuse reset", 1, 59, n);
    report_and_stop();
  end

  // Hang guard, well beyond the expected run of about 43000 cycles
  initial
  begin
    #(8 * 60000);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_wdg_watchdog
